// [logic/midi_bank_pkg.sv]
// types, register map and reset values for the midi bank/program select block
package midi_bank_pkg;
    typedef enum logic [1:0] {PSEL_OFF = 2'b00, PSEL_ON = 2'b01, PSEL_MIX = 2'b10} psel_e;
    typedef enum logic [1:0] {KM_FIXED = 2'b00, KM_LAYER = 2'b01, KM_SOLO = 2'b10} kbd_mode_e;
    typedef enum logic [1:0] {PC_NONE = 2'b00, PC_BANK = 2'b01, PC_PROG = 2'b10, PC_MIXSEL = 2'b11} panel_cmd_e;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SCAN = 2'b01, TX_BANK = 2'b10, TX_PROG = 2'b11} tx_state_e;
    typedef enum logic [1:0] {SRC_SINGLE = 2'b00, SRC_CHAN = 2'b01, SRC_MIX = 2'b10} src_e;

    typedef struct packed {
        logic [16:0] unused;
        logic card;
        logic [3:0] kbd_ch;
        kbd_mode_e kmode;
        logic [3:0] mix_ch;
        psel_e psel;
        logic gm;
        logic mix_mode;
    } ctrl_s;

    typedef struct packed {
        logic [14:0] unused;
        logic [6:0] prog;
        logic [3:0] bank;
        logic [3:0] chan;
        panel_cmd_e cmd;
    } panel_s;

    typedef struct packed {
        logic [7:0] unused;
        logic [6:0] sprog;
        logic [3:0] sbank;
        logic [6:0] mnum;
        logic [3:0] mbank;
        logic edited;
        logic busy;
    } status_s;

    // pc = 0: controller 0 (bank select), pc = 1: program change
    typedef struct packed {
        logic pc;
        logic [3:0] chan;
        logic [6:0] value;
    } midi_msg_s;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OUTEN_OFS = 8'h04;
    localparam logic [7:0] PANEL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] KEYS_OFS = 8'h10;
    localparam int STATUS_EDITED_BIT = 1;
    localparam ctrl_s CTRL_RST = ctrl_s'(32'h0000_0104);
    localparam logic [15:0] OUTEN_RST = 16'hFFFF;
    localparam logic [3:0] CARD_FIRST = 4'h5;
    localparam logic [3:0] LAST_CH = 4'hF;
endpackage

// [logic/midi_bank_program_select.sv]
// midi channel, bank select and program change handling with an ahb-lite register slave
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module midi_bank_program_select import midi_bank_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_valid,
    input wire midi_msg_s rx_msg,
    output logic tx_valid,
    input wire logic tx_ready,
    output midi_msg_s tx_msg,
    output logic [15:0] key_tx_mask,
    output logic local_enable
);
    typedef struct packed {
        ctrl_s ctrl;
        logic [15:0] out_en;
        logic [3:0] sbank;
        logic [6:0] sprog;
        logic [3:0] mbank;
        logic [6:0] mnum;
        logic edited;
        logic [15:0][3:0] cbank;
        logic [15:0][6:0] cprog;
        tx_state_e tx;
        logic [3:0] idx;
        logic [15:0] mask;
        logic do_bank;
        logic do_prog;
        src_e src;
        logic wr_pend;
        logic [7:0] waddr;
        logic [31:0] rdata;
    } st_s;

    st_s s;
    st_s n;
    psel_e psel_eff;
    kbd_mode_e kmode_eff;
    logic acc;
    logic busy;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [15:0] ch_bit(input logic [3:0] ch);
        ch_bit = 16'h0001 << ch;
    endfunction

    // low four bits pick the bank, so higher values wrap through the order
    function automatic logic bank_ok(input logic [6:0] v, input logic card);
        bank_ok = (v[3:0] < CARD_FIRST) || card;
    endfunction

    always_comb begin
        psel_eff = s.ctrl.gm ? PSEL_ON : (s.ctrl.psel == PSEL_OFF ? PSEL_OFF :
                   (s.ctrl.psel == PSEL_MIX ? PSEL_MIX : PSEL_ON));
        kmode_eff = s.ctrl.gm ? KM_SOLO : (s.ctrl.kmode == KM_FIXED ? KM_FIXED :
                    (s.ctrl.kmode == KM_SOLO ? KM_SOLO : KM_LAYER));
    end

    // keyboard routing toward the note path
    always_comb begin
        local_enable = kmode_eff != KM_FIXED;
        if (s.ctrl.mix_mode && kmode_eff == KM_LAYER) begin
            key_tx_mask = s.out_en;
        end else begin
            key_tx_mask = ch_bit(s.ctrl.kbd_ch);
        end
    end

    assign busy = s.tx != TX_IDLE;
    assign acc = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign tx_valid = s.tx == TX_BANK || s.tx == TX_PROG;

    always_comb begin
        tx_msg.pc = s.tx == TX_PROG;
        tx_msg.chan = s.idx;
        unique case (s.src)
            SRC_SINGLE: tx_msg.value = tx_msg.pc ? s.sprog : {3'h0, s.sbank};
            SRC_MIX: tx_msg.value = tx_msg.pc ? s.mnum : {3'h0, s.mbank};
            default: tx_msg.value = tx_msg.pc ? s.cprog[s.idx] : {3'h0, s.cbank[s.idx]};
        endcase
    end

    always_comb begin
        panel_s p;
        logic go;
        logic [15:0] sm;
        logic sb;
        logic sp;
        src_e ssrc;
        p = panel_s'(hwdata);
        go = 1'b0;
        sm = 16'h0000;
        sb = 1'b0;
        sp = 1'b0;
        ssrc = SRC_SINGLE;
        n = s;

        // ahb-lite: zero wait states, read data captured in the address phase
        n.wr_pend = acc && hwrite;
        n.waddr = haddr[7:0];
        if (acc && !hwrite) begin
            case (haddr[7:0])
                CTRL_OFS: n.rdata = s.ctrl;
                OUTEN_OFS: n.rdata = {16'h0000, s.out_en};
                STATUS_OFS: n.rdata = status_s'{8'h00, s.sprog, s.sbank, s.mnum, s.mbank, s.edited, busy};
                KEYS_OFS: n.rdata = {15'h0000, local_enable, key_tx_mask};
                default: n.rdata = 32'h0000_0000;
            endcase
        end

        // outgoing sweep over the channel mask, bank then program per channel
        unique case (s.tx)
            TX_IDLE: ;
            TX_SCAN: begin
                if (s.mask[s.idx]) begin
                    n.tx = s.do_bank ? TX_BANK : TX_PROG;
                end else if (s.idx == LAST_CH) begin
                    n.tx = TX_IDLE;
                end else begin
                    n.idx = s.idx + 4'h1;
                end
            end
            TX_BANK, TX_PROG: begin
                if (tx_ready) begin
                    if (s.tx == TX_BANK && s.do_prog) begin
                        n.tx = TX_PROG;
                    end else begin
                        n.mask[s.idx] = 1'b0;
                        n.tx = s.idx == LAST_CH ? TX_IDLE : TX_SCAN;
                        n.idx = s.idx + 4'h1;
                    end
                end
            end
        endcase
        if (psel_eff == PSEL_OFF) begin
            n.tx = TX_IDLE;
            n.mask = 16'h0000;
        end

        if (s.wr_pend) begin
            case (s.waddr)
                CTRL_OFS: n.ctrl = ctrl_s'(hwdata);
                OUTEN_OFS: n.out_en = hwdata[15:0];
                STATUS_OFS: if (hwdata[STATUS_EDITED_BIT]) n.edited = 1'b0;
                default: ;
            endcase
        end

        // panel commands are refused while a sweep is running
        if (s.wr_pend && s.waddr == PANEL_OFS && !busy) begin
            unique case (p.cmd)
                PC_NONE: ;
                PC_BANK: begin
                    go = 1'b1;
                    sb = 1'b1;
                    if (!s.ctrl.mix_mode) begin
                        n.sbank = p.bank;
                        sm = ch_bit(s.ctrl.kbd_ch);
                    end else if (psel_eff == PSEL_MIX) begin
                        n.mbank = p.bank;
                        sm = ch_bit(s.ctrl.mix_ch);
                        ssrc = SRC_MIX;
                    end else begin
                        n.mbank = p.bank;
                        sm = s.out_en;
                        sp = 1'b1;
                        ssrc = SRC_CHAN;
                    end
                end
                PC_PROG: begin
                    if (!s.ctrl.mix_mode) begin
                        n.sprog = p.prog;
                        go = 1'b1;
                        sp = 1'b1;
                        sm = ch_bit(s.ctrl.kbd_ch);
                    end else begin
                        n.cbank[p.chan] = p.bank;
                        n.cprog[p.chan] = p.prog;
                        go = psel_eff == PSEL_ON;
                        sb = 1'b1;
                        sp = 1'b1;
                        sm = s.out_en & ch_bit(p.chan);
                        ssrc = SRC_CHAN;
                    end
                end
                PC_MIXSEL: begin
                    n.mnum = p.prog;
                    n.edited = 1'b0;
                    go = psel_eff == PSEL_MIX;
                    sp = 1'b1;
                    sm = ch_bit(s.ctrl.mix_ch);
                    ssrc = SRC_MIX;
                end
            endcase
            if (go && psel_eff != PSEL_OFF) begin
                n.tx = TX_SCAN;
                n.idx = 4'h0;
                n.mask = sm;
                n.do_bank = sb;
                n.do_prog = sp;
                n.src = ssrc;
            end
        end

        // reception last, so a hardware set of edited beats a software clear
        if (rx_valid && psel_eff != PSEL_OFF) begin
            if (!s.ctrl.mix_mode) begin
                if (rx_msg.chan == s.ctrl.kbd_ch) begin
                    if (rx_msg.pc) begin
                        n.sprog = rx_msg.value;
                    end else if (!s.ctrl.gm && bank_ok(rx_msg.value, s.ctrl.card)) begin
                        n.sbank = rx_msg.value[3:0];
                    end
                end
            end else if (psel_eff == PSEL_MIX && rx_msg.chan == s.ctrl.mix_ch) begin
                if (rx_msg.pc) begin
                    n.mnum = rx_msg.value;
                end else if (bank_ok(rx_msg.value, s.ctrl.card)) begin
                    n.mbank = rx_msg.value[3:0];
                end
            end else if (rx_msg.pc) begin
                n.cprog[rx_msg.chan] = rx_msg.value;
                n.edited = 1'b1;
            end else if (!s.ctrl.gm && bank_ok(rx_msg.value, s.ctrl.card)) begin
                n.cbank[rx_msg.chan] = rx_msg.value[3:0];
                n.edited = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.out_en <= OUTEN_RST;
        end else begin
            s <= n;
        end
    end

    sequence s_rx_bank_prog;
        rx_valid && !rx_msg.pc && !s.ctrl.mix_mode && psel_eff != PSEL_OFF && !s.ctrl.gm
            && rx_msg.chan == s.ctrl.kbd_ch;
    endsequence

    sequence s_bank_taken;
        s.tx == TX_BANK && tx_ready && s.do_prog;
    endsequence

    property p_off_silent;
        psel_eff == PSEL_OFF |=> !tx_valid;
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("message sent with program select off");

    property p_rx_bank_map;
        logic [3:0] v;
        (s_rx_bank_prog ##0 (bank_ok(rx_msg.value, s.ctrl.card), v = rx_msg.value[3:0])) |=> s.sbank == v;
    endproperty
    a_rx_bank_map: assert property (p_rx_bank_map) else $error("received bank not mapped");

    property p_card_absent;
        s_rx_bank_prog ##0 (rx_msg.value[3:0] >= CARD_FIRST && !s.ctrl.card) |=> $stable(s.sbank);
    endproperty
    a_card_absent: assert property (p_card_absent) else $error("card bank taken without card");

    property p_gm_ignore;
        rx_valid && !rx_msg.pc && s.ctrl.gm |=> $stable(s.sbank) && $stable(s.cbank);
    endproperty
    a_gm_ignore: assert property (p_gm_ignore) else $error("bank change obeyed in gm mode");

    property p_mix_edit;
        rx_valid && !rx_msg.pc && s.ctrl.mix_mode && psel_eff == PSEL_ON && !s.ctrl.gm
            && bank_ok(rx_msg.value, s.ctrl.card) |=> s.edited && $stable(s.mbank);
    endproperty
    a_mix_edit: assert property (p_mix_edit) else $error("mix bank rx did not mark edited");

    property p_fixed_local;
        kmode_eff == KM_FIXED |-> !local_enable && key_tx_mask == ch_bit(s.ctrl.kbd_ch);
    endproperty
    a_fixed_local: assert property (p_fixed_local) else $error("fixed channel keeps local on");

    property p_gm_solo;
        s.ctrl.gm |-> local_enable && $onehot(key_tx_mask) && psel_eff == PSEL_ON;
    endproperty
    a_gm_solo: assert property (p_gm_solo) else $error("gm did not force solo and select on");

    property p_chan_enabled;
        tx_valid && s.src == SRC_CHAN |-> s.out_en[tx_msg.chan];
    endproperty
    a_chan_enabled: assert property (p_chan_enabled) else $error("sent on disabled channel");

    property p_bank_then_prog;
        logic [3:0] c;
        (s_bank_taken, c = tx_msg.chan) ##1 psel_eff != PSEL_OFF |-> tx_valid && tx_msg.pc && tx_msg.chan == c;
    endproperty
    a_bank_then_prog: assert property (p_bank_then_prog) else $error("program change did not follow bank");

    property p_mixsel_quiet;
        s.wr_pend && s.waddr == PANEL_OFS && !busy && hwdata[1:0] == PC_PROG
            && s.ctrl.mix_mode && psel_eff == PSEL_MIX |=> !busy [*2];
    endproperty
    a_mixsel_quiet: assert property (p_mixsel_quiet) else $error("mix program edit transmitted");
endmodule

// [tb/midi_far_end.sv]
// far-side model: a sequencer that takes transmitted midi messages, promptly or slowly
`timescale 1ns/1ps
module midi_far_end import midi_bank_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire midi_msg_s tx_msg
);
    midi_msg_s got[$];
    logic [1:0] ph_q;

    // slow mode takes one message in four cycles, to stretch the sweep
    assign tx_ready = !slow || (ph_q == 2'h3);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            if (tx_valid && tx_ready) begin
                got.push_back(tx_msg);
            end
        end
    end
endmodule

// [tb/midi_bank_program_select_test.sv]
// self-checking bench for the midi bank and program select block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module midi_bank_program_select_test import midi_bank_pkg::*; ;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_valid = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    midi_msg_s rx_msg = 12'h000, tx_msg;
    logic hreadyout, hresp, tx_valid, tx_ready, local_enable;
    logic [15:0] key_tx_mask;
    int fail_count = 0, compares = 0;
    // rows: ctrl, outen, expected {local_enable, key_tx_mask}
    logic [31:0] kt [4][3] = '{'{32'h0000_0C04, 32'h0000_00A5, 32'h0000_0008},
        '{32'h0000_0105, 32'h0000_00A5, 32'h0001_00A5}, '{32'h0000_1A05, 32'h0000_00A5, 32'h0001_0040},
        '{32'h0000_0907, 32'h0000_00A5, 32'h0001_0004}};
    logic [6:0] bv [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h0F, 7'h10, 7'h11, 7'h20, 7'h21};

    always #4 ref_clk = ~ref_clk;

    midi_bank_program_select i_midi_bank_program_select (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_msg(rx_msg),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_msg(tx_msg), .key_tx_mask(key_tx_mask),
        .local_enable(local_enable));
    midi_far_end i_midi_far_end (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_msg(tx_msg));

    function automatic midi_msg_s mm(input logic pc, input logic [3:0] ch, input logic [6:0] v);
        return {pc, ch, v};
    endfunction

    task automatic conclude;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rx(input logic pc, input logic [3:0] ch, input logic [6:0] v);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_msg <= mm(pc, ch, v);
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        bus(1'b0, STATUS_OFS, 32'h0000_0000);
    endtask

    // panel command, then poll busy with a bounded count
    task automatic pan(input logic [1:0] c, input logic [3:0] ch, input logic [3:0] b, input logic [6:0] p);
        i_midi_far_end.got.delete();
        bus(1'b1, PANEL_OFS, {15'h0000, p, b, ch, c});
        for (int i = 0; i < 64; i++) begin
            bus(1'b0, STATUS_OFS, 32'h0000_0000);
            if (rd[0] === 1'b0)
                break;
        end
        `CHK(rd[0], 1'b0)
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1'b0, KEYS_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0001_0001)
        `CHK({hresp, hreadyout}, 2'b01)
        bus(1'b0, 8'h20, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OUTEN_OFS, kt[i][1]);
            bus(1'b1, CTRL_OFS, kt[i][0]);
            bus(1'b0, KEYS_OFS, 32'h0000_0000);
            `CHK(rd, kt[i][2])
            `CHK({local_enable, key_tx_mask}, kt[i][2][16:0])
        end
        $display("test keyboard modes done");
        // program mode on channel 2 with a card present
        bus(1'b1, CTRL_OFS, 32'h0000_4804);
        foreach (bv[i]) begin
            rx(1'b0, 4'h2, bv[i]);
            `CHK(rd[16:13], bv[i][3:0])
        end
        rx(1'b0, 4'h3, 7'h03);
        `CHK(rd[16:13], 4'h1)
        rx(1'b1, 4'h2, 7'h2A);
        `CHK(rd[23:17], 7'h2A)
        bus(1'b1, CTRL_OFS, 32'h0000_0804);
        rx(1'b0, 4'h2, 7'h05);
        `CHK(rd[16:13], 4'h1)
        bus(1'b1, CTRL_OFS, 32'h0000_0806);
        rx(1'b0, 4'h2, 7'h03);
        `CHK(rd[16:13], 4'h1)
        bus(1'b1, CTRL_OFS, 32'h0000_0800);
        rx(1'b0, 4'h2, 7'h03);
        `CHK(rd[16:13], 4'h1)
        pan(PC_BANK, 4'h0, 4'h3, 7'h00);
        `CHK(i_midi_far_end.got.size(), 0)
        $display("test reception done");
        slow <= 1'b1;
        bus(1'b1, CTRL_OFS, 32'h0000_0804);
        pan(PC_BANK, 4'h0, 4'h3, 7'h00);
        `CHK(i_midi_far_end.got.size(), 1)
        `CHK(i_midi_far_end.got[0], mm(1'b0, 4'h2, 7'h03))
        pan(PC_PROG, 4'h0, 4'h0, 7'h11);
        `CHK(i_midi_far_end.got[0], mm(1'b1, 4'h2, 7'h11))
        // mix mode, select on, outputs on channels 1 and 2
        bus(1'b1, CTRL_OFS, 32'h0000_0005);
        bus(1'b1, OUTEN_OFS, 32'h0000_0006);
        pan(PC_PROG, 4'h1, 4'h2, 7'h09);
        `CHK(i_midi_far_end.got.size(), 2)
        `CHK(i_midi_far_end.got[0], mm(1'b0, 4'h1, 7'h02))
        `CHK(i_midi_far_end.got[1], mm(1'b1, 4'h1, 7'h09))
        pan(PC_PROG, 4'h3, 4'h1, 7'h07);
        `CHK(i_midi_far_end.got.size(), 0)
        bus(1'b1, OUTEN_OFS, 32'h0000_000A);
        pan(PC_BANK, 4'h0, 4'h4, 7'h00);
        `CHK(i_midi_far_end.got.size(), 4)
        `CHK(i_midi_far_end.got[1], mm(1'b1, 4'h1, 7'h09))
        `CHK(i_midi_far_end.got[2], mm(1'b0, 4'h3, 7'h01))
        `CHK(i_midi_far_end.got[3], mm(1'b1, 4'h3, 7'h07))
        rx(1'b0, 4'h5, 7'h03);
        `CHK(rd[5:1], 5'h09)
        $display("test mix select on done");
        // mix select on channel 3
        bus(1'b1, CTRL_OFS, 32'h0000_0039);
        rx(1'b1, 4'h3, 7'h16);
        `CHK(rd[12:6], 7'h16)
        rx(1'b0, 4'h3, 7'h02);
        `CHK(rd[5:2], 4'h2)
        pan(PC_BANK, 4'h0, 4'h6, 7'h00);
        `CHK(i_midi_far_end.got[0], mm(1'b0, 4'h3, 7'h06))
        pan(PC_MIXSEL, 4'h0, 4'h0, 7'h0D);
        `CHK(i_midi_far_end.got[0], mm(1'b1, 4'h3, 7'h0D))
        `CHK(rd[12:1], {7'h0D, 4'h6, 1'b0})
        pan(PC_PROG, 4'h1, 4'h2, 7'h05);
        `CHK(i_midi_far_end.got.size(), 0)
        $display("test mix select channel done");
        conclude();
    end
endmodule
